// ---- src/icu_compare_unit.sv ----
// Purpose: integer compare execute unit with register-file write-back
// Assumes: register file read ports answer combinationally, same clock
// Notes:   one result per cycle, no stall and no exception path
//
// Behaviour
// - signed register less-than writes one or zero
// - unsigned register less-than writes one or zero
// - signed immediate less-than sign-extends sixteen bits
// - register compares decoded by opcode and extended opcode
// - source and destination indices from fixed fields
// - immediate less-than opcode, immediate field, destination
// - compares raise no exception
// - signed register greater-equal under extended opcode
// - unsigned register greater-equal under extended opcode
// - greater-equal immediates extend by signedness
// - unsigned immediate less-than zero-extends immediate
`timescale 1ns/1ps
`include "icu_defines.svh"

module icu_compare_unit
   import icu_pkg::*;
#(
   parameter int DATA_W = 32
)
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   // instruction from decode stage
   input  wire logic              instr_valid,
   input  wire logic [31:0]       instr,
   // register file read ports
   output logic [4:0]             first_source_register,
   output logic [4:0]             second_source_register,
   input  wire logic [DATA_W-1:0] src_a_data,
   input  wire logic [DATA_W-1:0] src_b_data,
   // register file write port
   output logic                   rf_wr_en,
   output logic [4:0]             destination_register,
   output logic [DATA_W-1:0]      rf_wr_data,
   // status
   output logic                   cmp_accepted,
   output logic                   cmp_exception
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [DATA_W-1:0] extend_imm(input logic [15:0] imm,
                                                    input logic        sgn);
      extend_imm = {{(DATA_W-16){sgn & imm[15]}}, imm};
   endfunction

   function automatic logic less_than(input logic [DATA_W-1:0] a,
                                      input logic [DATA_W-1:0] b,
                                      input logic              sgn);
      // flipping the sign bits turns a signed order into an unsigned one
      less_than = ({a[DATA_W-1] ^ sgn, a[DATA_W-2:0]} <
                   {b[DATA_W-1] ^ sgn, b[DATA_W-2:0]});
   endfunction

   // ----------------------------------------
   // decode
   // ----------------------------------------
   icu_dec_t dec;

   icu_decode u_decode
   (
      .instr (instr),
      .dec   (dec)
   );

   // ----------------------------------------
   // execute
   // ----------------------------------------
   logic [DATA_W-1:0] opnd_b;
   logic              lt_s;
   logic              lt_u;
   logic              outcome;

   always_comb
   begin
      first_source_register  = dec.src_a_idx;
      second_source_register = dec.src_b_idx;
      opnd_b = dec.use_imm ? extend_imm(dec.sixteen_bit_immediate, dec.imm_signed)
                           : src_b_data;
      lt_s   = less_than(src_a_data, opnd_b, 1'b1);
      lt_u   = less_than(src_a_data, opnd_b, 1'b0);
      unique case (dec.cmp)
         ICU_CMP_LT  : outcome = lt_s;
         ICU_CMP_LTU : outcome = lt_u;
         ICU_CMP_GE  : outcome = ~lt_s;
         ICU_CMP_GEU : outcome = ~lt_u;
         default     : outcome = 1'b0;
      endcase
   end

   // ----------------------------------------
   // write-back stage
   // ----------------------------------------
   icu_wb_t wb_d;
   icu_wb_t wb_q;
   logic    acc_d;
   logic    acc_q;

   always_comb
   begin
      wb_d.wr_en   = instr_valid & dec.valid;
      wb_d.wr_idx  = dec.dst_idx;
      wb_d.wr_data = {{(DATA_W-1){1'b0}}, outcome};
      acc_d        = instr_valid & dec.valid;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wb_q  <= '{wr_en: 1'b0, wr_idx: `ICU_RST_IDX, wr_data: `ICU_RST_WORD};
         acc_q <= 1'b0;
      end
      else
      begin
         wb_q  <= wb_d;
         acc_q <= acc_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_comb
   begin
      rf_wr_en             = wb_q.wr_en;
      destination_register = wb_q.wr_idx;
      rf_wr_data           = wb_q.wr_data;
      cmp_accepted         = acc_q;
      // compares never trap, so this flag stays low
      cmp_exception        = 1'b0;
   end

endmodule // icu_compare_unit

// ---- src/icu_decode.sv ----
// Purpose: decode of compare instructions into a control struct
// Assumes: instruction word from same-clock fetch/decode stage
// Notes:   purely combinational, no exception outputs at all
`timescale 1ns/1ps
`include "icu_defines.svh"

module icu_decode
   import icu_pkg::*;
(
   // instruction
   input  wire logic [31:0] instr,
   // decoded control
   output icu_dec_t         dec
);

   logic [5:0] op;
   logic [5:0] xop;
   logic       shamt_zero;

   always_comb
   begin
      op         = instr[`ICU_OP_MSB:`ICU_OP_LSB];
      xop        = instr[`ICU_XOP_MSB:`ICU_XOP_LSB];
      shamt_zero = (instr[`ICU_SHAMT_MSB:`ICU_SHAMT_LSB] == 5'h00);
      dec                       = '0;
      dec.src_a_idx             = instr[`ICU_SRCA_MSB:`ICU_SRCA_LSB];
      dec.src_b_idx             = instr[`ICU_SRCB_MSB:`ICU_SRCB_LSB];
      dec.sixteen_bit_immediate = instr[`ICU_IMM_MSB:`ICU_IMM_LSB];
      dec.cmp                   = ICU_CMP_NONE;
      if (op == `ICU_OP_RTYPE && shamt_zero)
      begin
         dec.dst_idx = instr[`ICU_DST_MSB:`ICU_DST_LSB];
         unique case (xop)
            `ICU_XOP_LT  : dec.cmp = ICU_CMP_LT;
            `ICU_XOP_LTU : dec.cmp = ICU_CMP_LTU;
            `ICU_XOP_GE  : dec.cmp = ICU_CMP_GE;
            `ICU_XOP_GEU : dec.cmp = ICU_CMP_GEU;
            default      : dec.cmp = ICU_CMP_NONE;
         endcase
      end
      else
      begin
         // immediate forms write the second source register
         dec.dst_idx = instr[`ICU_SRCB_MSB:`ICU_SRCB_LSB];
         dec.use_imm = 1'b1;
         unique case (op)
            `ICU_OP_LT_IMM  :
            begin
               dec.cmp        = ICU_CMP_LT;
               dec.imm_signed = 1'b1;
            end
            `ICU_OP_LTU_IMM : dec.cmp = ICU_CMP_LTU;
            `ICU_OP_GE_IMM  :
            begin
               dec.cmp        = ICU_CMP_GE;
               dec.imm_signed = 1'b1;
            end
            `ICU_OP_GEU_IMM : dec.cmp = ICU_CMP_GEU;
            default         : dec.cmp = ICU_CMP_NONE;
         endcase
      end
      dec.valid = (dec.cmp != ICU_CMP_NONE);
   end

endmodule // icu_decode

// ---- src/icu_defines.svh ----
// Purpose: constants of the integer compare unit
// Assumes: 32-bit instruction and data words
// Notes:   field positions, opcodes and timing
`ifndef ICU_DEFINES_SVH
`define ICU_DEFINES_SVH

// ----------------------------------------
// primary and extended opcodes
// ----------------------------------------
`define ICU_OP_RTYPE      6'h3a
`define ICU_OP_LT_IMM     6'h10
`define ICU_OP_LTU_IMM    6'h30
`define ICU_OP_GE_IMM     6'h08
`define ICU_OP_GEU_IMM    6'h28
`define ICU_XOP_LT        6'h10
`define ICU_XOP_LTU       6'h30
`define ICU_XOP_GE        6'h08
`define ICU_XOP_GEU       6'h28

// ----------------------------------------
// instruction field positions
// ----------------------------------------
`define ICU_OP_LSB        0
`define ICU_OP_MSB        5
`define ICU_SHAMT_LSB     6
`define ICU_SHAMT_MSB     10
`define ICU_XOP_LSB       11
`define ICU_XOP_MSB       16
`define ICU_IMM_LSB       6
`define ICU_IMM_MSB       21
`define ICU_DST_LSB       17
`define ICU_DST_MSB       21
`define ICU_SRCB_LSB      22
`define ICU_SRCB_MSB      26
`define ICU_SRCA_LSB      27
`define ICU_SRCA_MSB      31

// ----------------------------------------
// reset values and latency
// ----------------------------------------
`define ICU_RST_WORD      32'h0000_0000
`define ICU_RST_IDX       5'h00
`define ICU_LATENCY       1

`endif

// ---- src/icu_pkg.sv ----
// Purpose: types of the integer compare unit
// Assumes: field widths written as literals, no defines included
// Notes:   shared by the decoder and the top
package icu_pkg;

   typedef enum logic [2:0]
   {
      ICU_CMP_NONE,
      ICU_CMP_LT,
      ICU_CMP_LTU,
      ICU_CMP_GE,
      ICU_CMP_GEU
   } icu_cmp_t;

   typedef struct packed
   {
      logic        valid;
      icu_cmp_t    cmp;
      logic        use_imm;
      logic        imm_signed;
      logic [4:0]  src_a_idx;
      logic [4:0]  src_b_idx;
      logic [4:0]  dst_idx;
      logic [15:0] sixteen_bit_immediate;
   } icu_dec_t;

   typedef struct packed
   {
      logic        wr_en;
      logic [4:0]  wr_idx;
      logic [31:0] wr_data;
   } icu_wb_t;

endpackage

// ---- tb/icu_compare_unit_monitor.sv ----
// Purpose: port checks of the compare unit
// Assumes: bound onto icu_compare_unit
// Notes:   decode rebuilt from the instruction fields
`timescale 1ns/1ps
module icu_compare_unit_monitor #(parameter int DATA_W = 32)
(
   // clock, reset and instruction
   input wire logic              clk_sys,
   input wire logic              rst_b,
   input wire logic              instr_valid,
   input wire logic [31:0]       instr,
   // register file side
   input wire logic [4:0]        first_source_register,
   input wire logic [4:0]        second_source_register,
   input wire logic [DATA_W-1:0] src_a_data,
   input wire logic [DATA_W-1:0] src_b_data,
   input wire logic              rf_wr_en,
   input wire logic [4:0]        destination_register,
   input wire logic [DATA_W-1:0] rf_wr_data,
   // status
   input wire logic              cmp_accepted,
   input wire logic              cmp_exception
);
   // ----------------------------------------
   // decode rebuild
   // ----------------------------------------
   wire rt = instr[5:0] == 6'h3a && instr[10:6] == 5'h00;
   wire [5:0] sel = rt ? instr[16:11] : instr[5:0];
   wire take = instr_valid && sel inside {6'h10, 6'h30, 6'h08, 6'h28};
   wire [31:0] ob_s = rt ? src_b_data : {{16{instr[21]}}, instr[21:6]};
   wire [31:0] ob_u = rt ? src_b_data : {16'h0000, instr[21:6]};
   wire lt_s = $signed(src_a_data) < $signed(ob_s);
   wire lt_u = src_a_data < ob_u;
   wire [4:0] dst_x = rt ? instr[21:17] : instr[26:22];
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_take(c);
      take && sel == c;
   endsequence
   a_take_write:
      assert property (take |=> rf_wr_en && cmp_accepted) else $error("compare not written");
   a_refuse_write:
      assert property (!take |=> !rf_wr_en) else $error("write without compare");
   a_lt_signed:
      assert property (s_take(6'h10) |=> rf_wr_data[0] == $past(lt_s)) else $error("lt bad");
   a_lt_unsigned:
      assert property (s_take(6'h30) |=> rf_wr_data[0] == $past(lt_u)) else $error("ltu bad");
   a_ge_signed:
      assert property (s_take(6'h08) |=> rf_wr_data[0] != $past(lt_s)) else $error("ge bad");
   a_ge_unsigned:
      assert property (s_take(6'h28) |=> rf_wr_data[0] != $past(lt_u)) else $error("geu bad");
   a_upper_zero:
      assert property (rf_wr_en |-> rf_wr_data[31:1] == 31'h0) else $error("upper bits set");
   a_no_exception:
      assert property (!cmp_exception) else $error("exception raised");
   a_src_index:
      assert property (first_source_register == instr[31:27]
         && second_source_register == instr[26:22]) else $error("read index bad");
   a_dst_index:
      assert property (take |=> destination_register == $past(dst_x)) else $error("dst bad");
endmodule // icu_compare_unit_monitor

// ---- tb/icu_rf_model.sv ----
// Purpose: register file read model
// Assumes: reads answer in the same cycle
// Notes:   contents are salt plus index
`timescale 1ns/1ps
module icu_rf_model
(
   // read ports
   input  wire logic [4:0]  idx_a,
   input  wire logic [4:0]  idx_b,
   input  wire logic [31:0] salt,
   output logic [31:0]      data_a,
   output logic [31:0]      data_b
);
   // one salt reshuffles every register, so boundaries are cheap to reach
   assign data_a = salt + 32'(idx_a);
   assign data_b = salt + 32'(idx_b);
endmodule // icu_rf_model

// ---- tb/tb_icu_compare_unit.sv ----
// Purpose: self-checking bench of the compare unit
// Assumes: register file model answers in the same cycle
// Notes:   boundary, pseudo-form and random compares, back to back
`timescale 1ns/1ps
module tb_icu_compare_unit;
   logic        clk_sys = 0, rst_b = 0, instr_valid = 0, wr_en, acc, exc;
   logic [31:0] instr = 0, salt = 0, a_d, b_d, rf_wr_data;
   logic [4:0]  ia, ib, dst;
   int          errors = 0, n_tests = 0;
   initial forever #20 clk_sys = ~clk_sys;
   icu_compare_unit u_icu_compare_unit (.clk_sys, .rst_b, .instr_valid, .instr,
      .first_source_register(ia), .second_source_register(ib), .src_a_data(a_d),
      .src_b_data(b_d), .rf_wr_en(wr_en), .destination_register(dst), .rf_wr_data,
      .cmp_accepted(acc), .cmp_exception(exc));
   icu_rf_model u_icu_rf_model (.idx_a(ia), .idx_b(ib), .salt, .data_a(a_d), .data_b(b_d));
   // ----------------------------------------
   // reference model, one result per edge
   // ----------------------------------------
   always @(posedge clk_sys)
   begin : ref_chk
      logic en, lt, rt;
      logic [5:0] s;
      logic [4:0] ix;
      longint sa, sb, ua, ub;
      rt = instr[5:0] == 6'h3a && instr[10:6] == 5'h00;
      s = rt ? instr[16:11] : instr[5:0];
      en = rst_b && instr_valid && s inside {6'h10, 6'h30, 6'h08, 6'h28};
      sa = longint'($signed(a_d));
      ua = longint'(a_d);
      sb = rt ? longint'($signed(b_d)) : longint'($signed(instr[21:6]));
      ub = rt ? longint'(b_d) : longint'(instr[21:6]);
      lt = s == 6'h10 ? sa < sb : s == 6'h30 ? ua < ub : s == 6'h08 ? sa >= sb : ua >= ub;
      ix = rt ? instr[21:17] : instr[26:22];
      #1;
      n_tests++;
      if (wr_en !== en || acc !== en || exc !== 1'b0)
      begin
         errors++;
         $display("MISMATCH %0t write strobe or status differs", $time);
      end
      if (en && dst !== ix)
      begin
         errors++;
         $display("MISMATCH %0t destination index differs", $time);
      end
      if (en && rf_wr_data !== {31'h0, lt})
      begin
         errors++;
         $display("MISMATCH %0t compare result differs", $time);
      end
   end
   task automatic issue(input logic v, input logic [31:0] w, input logic [31:0] s);
      @(posedge clk_sys);
      instr_valid <= v;
      instr <= w;
      salt <= s;
   endtask
   function automatic logic [31:0] enc_r(logic [5:0] x, logic [4:0] a, b, c);
      return {a, b, c, x, 5'h00, 6'h3a};
   endfunction
   function automatic logic [31:0] enc_i(logic [5:0] o, logic [15:0] k);
      return {5'h01, 5'h02, k, o};
   endfunction
   task automatic wrap_up();
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin : watchdog
      #50us;
      errors++;
      wrap_up();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin : main
      logic [5:0] ops [4];
      logic [31:0] w;
      int r;
      ops = '{6'h10, 6'h30, 6'h08, 6'h28};
      void'($urandom(45));
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      // signed and unsigned order disagree across the sign boundary
      foreach (ops[i])
      begin
         issue(1, enc_r(ops[i], 5'h01, 5'h00, 5'h03), 32'h7fff_ffff);
         issue(1, enc_i(ops[i], 16'h8000), 32'hffff_7fff);
      end
      // pseudo forms at the extreme constants
      issue(1, enc_i(6'h10, 16'h7fff), 32'h0000_7ffd);
      issue(1, enc_i(6'h10, 16'h8000), 32'hffff_7ffe);
      issue(1, enc_i(6'h30, 16'hffff), 32'h0000_fffd);
      issue(1, enc_i(6'h08, 16'h7fff), 32'h0000_7ffe);
      issue(1, enc_i(6'h28, 16'h0001), 32'hffff_ffff);
      issue(1, enc_r(6'h30, 5'h02, 5'h01, 5'h04), $urandom);
      issue(1, enc_r(6'h08, 5'h02, 5'h01, 5'h05), $urandom);
      issue(1, enc_r(6'h28, 5'h02, 5'h01, 5'h06), $urandom);
      repeat (400)
      begin
         r = $urandom_range(9);
         w = $urandom;
         if (r < 4)
            w = enc_r(ops[r], w[31:27], w[26:22], w[21:17]);
         else if (r < 8)
            w[5:0] = ops[r-4];
         else if (r == 8)
            w = {w[31:17], ops[0], w[10:7], 1'b1, 6'h3a};
         issue($urandom_range(7) != 0, w, $urandom);
      end
      issue(0, 0, 0);
      repeat (2) @(posedge clk_sys);
      wrap_up();
   end
endmodule // tb_icu_compare_unit
bind icu_compare_unit icu_compare_unit_monitor #(.DATA_W(DATA_W)) u_icu_compare_unit_monitor (
   .clk_sys, .rst_b, .instr_valid, .instr, .first_source_register, .second_source_register,
   .src_a_data, .src_b_data, .rf_wr_en, .destination_register, .rf_wr_data,
   .cmp_accepted, .cmp_exception);
